/* File: cats_fifo.sv */
`timescale 1ns/1ps
module cats_fifo
  import cats_pkg::*;
#(
  parameter int WIDTH = 16,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input  wire logic             core_clk_i,
  input  wire logic             rst_b_i,
  input  wire logic             flush_i,
  // Fill side
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } cats_fifo_st_s;

  logic [WIDTH-1:0] mem [DEPTH];
  cats_fifo_st_s    st_r;
  cats_fifo_st_s    st_nxt;
  logic             push;
  logic             pop;

  assign in_ready_o  = (st_r.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (st_r.cnt != '0);
  assign out_data_o  = mem[st_r.rp];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  always_comb begin
    st_nxt = st_r;
    if (push) begin
      st_nxt.wp = (st_r.wp == AW'(DEPTH-1)) ? '0 : st_r.wp + 1'b1;
    end
    if (pop) begin
      st_nxt.rp = (st_r.rp == AW'(DEPTH-1)) ? '0 : st_r.rp + 1'b1;
    end
    st_nxt.cnt = st_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
    if (flush_i) begin
      st_nxt = '0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
    if (push) begin
      mem[st_r.wp] <= in_data_i;
    end
  end
endmodule // cats_fifo

/* File: cats_host_model.sv */
`timescale 1ns/1ps
module cats_host_model
  import cats_pkg::*;
(
  // Register port
  input  wire logic          core_clk_i,
  output cats_bus_req_s      bus_req_o,
  input  wire cats_bus_rsp_s bus_rsp_i
);
  initial bus_req_o = '0;

  // One access per call; the request stands for exactly one taking edge
  task automatic xfer(input logic we, input logic [15:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge core_clk_i);
    bus_req_o <= '{req: 1'b1, we: we, addr: a, wdata: d};
    @(posedge core_clk_i);
    // Released lines show the inverse so a stale value never looks valid
    bus_req_o <= '{req: 1'b0, we: 1'b0, addr: ~a, wdata: ~d};
    @(posedge core_clk_i);
    q = bus_rsp_i.ack ? bus_rsp_i.rdata : 16'hbad0;
  endtask
endmodule // cats_host_model

/* File: cats_pkg.sv */
package cats_pkg;
  // Register offsets (byte addresses within the board window)
  localparam logic [15:0] CATS_OFF_MODE_SET   = 16'h1032;
  localparam logic [15:0] CATS_OFF_MODE_CLR   = 16'h1034;
  localparam logic [15:0] CATS_OFF_WR_ADDR    = 16'h1036;
  localparam logic [15:0] CATS_OFF_PAT_UPPER  = 16'h1038;
  localparam logic [15:0] CATS_OFF_PAT_LOWER  = 16'h103a;
  localparam logic [15:0] CATS_OFF_CHASSIS    = 16'h103c;
  localparam logic [15:0] CATS_OFF_TEST_EVT   = 16'h103e;
  localparam logic [15:0] CATS_OFF_EVCNT_CLR  = 16'h1040;
  localparam logic [15:0] CATS_OFF_BASELINE   = 16'h1060;
  localparam logic [15:0] CATS_OFF_RD_ADDR    = 16'h1064;
  localparam logic [15:0] CATS_OFF_SW_CONV    = 16'h1068;
  localparam logic [15:0] CATS_OFF_SLIDE      = 16'h106a;
  localparam logic [15:0] CATS_OFF_BLOCK_A    = 16'h1070;
  localparam logic [15:0] CATS_OFF_BLOCK_B    = 16'h1072;

  // Mode register field positions
  localparam int CATS_MODE_TEST_MEM  = 0;
  localparam int CATS_MODE_DATA_RST  = 2;
  localparam int CATS_MODE_ACQUISITION_TEST_SELECT  = 6;
  localparam int CATS_MODE_SLIDE_ON  = 7;

  // Reset values
  localparam logic [15:0] CATS_MODE_RST       = 16'h0080;
  localparam logic [7:0]  CATS_BASE_RST_NEW   = 8'hb4;
  localparam logic [7:0]  CATS_BASE_RST_OLD   = 8'h00;
  localparam logic [7:0]  CATS_CHASSIS_RST    = 8'h00;
  localparam logic [7:0]  CATS_SLIDE_RST      = 8'h00;

  // Field widths, event store depth and overflow bit position
  localparam int CATS_OB_AW   = 11;
  localparam int CATS_SAMPLE_W = 12;
  localparam int CATS_EVT_WORDS = 32;
  localparam int CATS_OVF_BIT  = 12;

  typedef enum logic [1:0] {
    CATS_ACQ_IDLE  = 2'b00,
    CATS_ACQ_DRAIN = 2'b01,
    CATS_ACQ_DONE  = 2'b10
  } cats_acq_e;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] addr;
    logic [15:0] wdata;
  } cats_bus_req_s;

  typedef struct packed {
    logic        ack;
    logic [15:0] rdata;
  } cats_bus_rsp_s;

  typedef struct packed {
    logic                  we;
    logic [CATS_OB_AW-1:0] addr;
    logic [31:0]           data;
  } cats_ob_wr_s;
endpackage

/* File: cats_regs.sv */
`timescale 1ns/1ps
// Operation
// - Clear register drops mode bits written one
// - Writing 0x4 clears data-reset request
// - Write test address holds 11-bit location
// - Pattern built from upper and lower halves
// - Lower-word write commits pattern to buffer
// - Chassis index stored, inserted into data
// - Test words pushed; acquisition test drains event
// - Test word: 12-bit sample plus overflow
// - Write to clear location zeroes event count
// - Baseline code 8-bit, default 180 new
// - Old boards default zero, host uses 120
// - Read test address holds 11-bit location
// - Trigger location write starts test conversion
// - Sliding constant 8-bit drives DAC when off
// - Block A register returns latest sample
// - Block B register returns latest sample
// - Mode write sets ones, read returns bits
// - Data-reset request clears buffers and count
// - Sliding off drives DAC with constant
module cats_regs
  import cats_pkg::*;
#(
  parameter bit          NEW_FRONT_END = 1'b1,
  parameter int          EVT_WORDS     = CATS_EVT_WORDS,
  parameter int          EVCNT_W       = 24
) (
  // Clock and reset
  input  wire logic                     core_clk_i,
  input  wire logic                     rst_b_i,
  // Register access port
  input  wire cats_bus_req_s            bus_req_i,
  output cats_bus_rsp_s                 bus_rsp_o,
  // Analog block samples
  input  wire logic [CATS_SAMPLE_W-1:0] block_a_raw_sample_i,
  input  wire logic [CATS_SAMPLE_W-1:0] block_b_raw_sample_i,
  // Event counter increment from trigger logic
  input  wire logic                     event_inc_i,
  // Output buffer write port
  output cats_ob_wr_s                   ob_wr_o,
  input  wire logic                     ob_ready_i,
  // Mode and setup outputs
  output logic [15:0]                   mode_o,
  output logic [CATS_OB_AW-1:0]         read_test_address_o,
  output logic [7:0]                    chassis_index_o,
  output logic [7:0]                    baseline_current_code_o,
  output logic [7:0]                    slide_dac_o,
  output logic                          sliding_scale_on_o,
  output logic                          data_reset_o,
  output logic                          conv_trigger_o,
  output logic [EVCNT_W-1:0]            event_count_o
);
  localparam int EAW = $clog2(EVT_WORDS);

  typedef struct packed {
    logic [15:0]                  mode;
    logic [CATS_OB_AW-1:0]        wr_addr;
    logic [CATS_OB_AW-1:0]        rd_addr;
    logic [15:0]                  pat_upper;
    logic [7:0]                   chassis;
    logic [7:0]                   baseline;
    logic [7:0]                   slide;
    logic [EAW-1:0]               evt_wp;
    logic [EAW-1:0]               evt_rp;
    logic [EAW:0]                 drain_left;
    cats_acq_e                    acq;
    logic [CATS_OB_AW-1:0]        acq_addr;
    logic [EVCNT_W-1:0]           evcnt;
    logic                         conv;
    logic                         ack;
    logic [15:0]                  rdata;
    cats_ob_wr_s                  ob;
    logic [CATS_SAMPLE_W-1:0]     smp_a;
    logic [CATS_SAMPLE_W-1:0]     smp_b;
  } cats_st_s;

  // Event store: 32 test words, overwrite on wrap
  logic [15:0]  evt_mem [EVT_WORDS];
  cats_st_s     st_r;
  cats_st_s     st_nxt;
  logic         ob_take;
  logic [CATS_SAMPLE_W-1:0] sa_m;
  logic [CATS_SAMPLE_W-1:0] sb_m;
  logic         wr;
  logic         rd;
  logic         evt_push;
  logic         fifo_in_ready;
  logic         fifo_in_valid;
  logic         fifo_out_valid;
  logic [15:0]  fifo_out_data;
  logic [15:0]  drain_word;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
    return a == off;
  endfunction

  assign wr       = bus_req_i.req && bus_req_i.we;
  assign rd       = bus_req_i.req && !bus_req_i.we;
  assign evt_push = wr && hit(bus_req_i.addr, CATS_OFF_TEST_EVT);
  assign drain_word = evt_mem[st_r.evt_rp];
  assign fifo_in_valid = (st_r.acq == CATS_ACQ_DRAIN);

  // Samples arrive from the analog side; staged through two flops
  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      sa_m       <= '0;
      sb_m       <= '0;
    end else begin
      sa_m <= block_a_raw_sample_i;
      sb_m <= block_b_raw_sample_i;
    end
  end

  always_comb begin
    st_nxt       = st_r;
    st_nxt.ack   = bus_req_i.req;
    st_nxt.conv  = 1'b0;
    st_nxt.ob.we = 1'b0;
    st_nxt.smp_a = sa_m;
    st_nxt.smp_b = sb_m;
    if (event_inc_i) begin
      st_nxt.evcnt = st_r.evcnt + 1'b1;
    end
    if (wr) begin
      unique case (bus_req_i.addr)
        CATS_OFF_MODE_SET:  st_nxt.mode = st_r.mode | bus_req_i.wdata;
        CATS_OFF_MODE_CLR:  st_nxt.mode = st_r.mode & ~bus_req_i.wdata;
        CATS_OFF_WR_ADDR:   st_nxt.wr_addr = bus_req_i.wdata[CATS_OB_AW-1:0];
        CATS_OFF_RD_ADDR:   st_nxt.rd_addr = bus_req_i.wdata[CATS_OB_AW-1:0];
        CATS_OFF_PAT_UPPER: st_nxt.pat_upper = bus_req_i.wdata;
        CATS_OFF_PAT_LOWER: begin
          // Commit only in memory test mode
          if (st_r.mode[CATS_MODE_TEST_MEM]) begin
            st_nxt.ob.we   = 1'b1;
            st_nxt.ob.addr = st_r.wr_addr;
            st_nxt.ob.data = {st_r.pat_upper, bus_req_i.wdata};
          end
        end
        CATS_OFF_CHASSIS:   st_nxt.chassis = bus_req_i.wdata[7:0];
        CATS_OFF_TEST_EVT:  st_nxt.evt_wp = st_r.evt_wp + 1'b1;
        CATS_OFF_EVCNT_CLR: st_nxt.evcnt = '0;
        CATS_OFF_BASELINE:  st_nxt.baseline = bus_req_i.wdata[7:0];
        CATS_OFF_SW_CONV:   st_nxt.conv = 1'b1;
        CATS_OFF_SLIDE:     st_nxt.slide = bus_req_i.wdata[7:0];
        default: ;
      endcase
    end
    // Read mux: side-effect free for every location
    st_nxt.rdata = 16'h0000;
    if (rd) begin
      unique case (bus_req_i.addr)
        CATS_OFF_MODE_SET:  st_nxt.rdata = st_r.mode;
        CATS_OFF_CHASSIS:   st_nxt.rdata = {8'h00, st_r.chassis};
        CATS_OFF_BASELINE:  st_nxt.rdata = {8'h00, st_r.baseline};
        CATS_OFF_SLIDE:     st_nxt.rdata = {8'h00, st_r.slide};
        CATS_OFF_BLOCK_A:   st_nxt.rdata = {4'h0, st_r.smp_a};
        CATS_OFF_BLOCK_B:   st_nxt.rdata = {4'h0, st_r.smp_b};
        default:            st_nxt.rdata = 16'h0000;
      endcase
    end
    // Acquisition test: drain the stored event through the FIFO
    unique case (st_r.acq)
      CATS_ACQ_IDLE: begin
        if (st_r.mode[CATS_MODE_ACQUISITION_TEST_SELECT]) begin
          st_nxt.acq        = CATS_ACQ_DRAIN;
          st_nxt.evt_rp     = st_r.evt_wp;
          st_nxt.drain_left = (EAW+1)'(EVT_WORDS);
        end
      end
      CATS_ACQ_DRAIN: begin
        if (fifo_in_ready) begin
          st_nxt.evt_rp     = st_r.evt_rp + 1'b1;
          st_nxt.drain_left = st_r.drain_left - 1'b1;
          if (st_r.drain_left == (EAW+1)'(1)) begin
            st_nxt.acq = CATS_ACQ_DONE;
          end
        end
      end
      CATS_ACQ_DONE: begin
        // One event per setting of the select bit
        if (!st_r.mode[CATS_MODE_ACQUISITION_TEST_SELECT]) begin
          st_nxt.acq = CATS_ACQ_IDLE;
        end
      end
      default: st_nxt.acq = CATS_ACQ_IDLE;
    endcase
    // Pop decided after a pattern commit claims the port, so a commit write holds off the pop
    ob_take = fifo_out_valid && ob_ready_i && !st_nxt.ob.we;
    if (ob_take) begin
      st_nxt.ob.we   = 1'b1;
      st_nxt.ob.addr = st_r.acq_addr;
      // Chassis index in upper half, overflow flag and sample below
      st_nxt.ob.data = {8'h00, st_r.chassis, 3'h0, fifo_out_data[CATS_OVF_BIT:0]};
      st_nxt.acq_addr = st_r.acq_addr + 1'b1;
    end
    // Held request keeps buffer pointers and count at zero
    if (st_r.mode[CATS_MODE_DATA_RST]) begin
      st_nxt.evcnt    = '0;
      st_nxt.acq_addr = '0;
      st_nxt.evt_wp   = '0;
      st_nxt.evt_rp   = '0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_b_i) begin
      st_r          <= '0;
      st_r.mode     <= CATS_MODE_RST;
      st_r.chassis  <= CATS_CHASSIS_RST;
      st_r.baseline <= NEW_FRONT_END ? CATS_BASE_RST_NEW : CATS_BASE_RST_OLD;
      st_r.slide    <= CATS_SLIDE_RST;
      st_r.acq      <= CATS_ACQ_IDLE;
    end else begin
      st_r <= st_nxt;
    end
    if (evt_push) begin
      evt_mem[st_r.evt_wp] <= bus_req_i.wdata;
    end
  end

  // Back-pressure from the output buffer stalls the drain
  cats_fifo #(
    .WIDTH (16),
    .DEPTH (4)
  ) u_fifo (
    .core_clk_i  (core_clk_i),
    .rst_b_i     (rst_b_i),
    .flush_i     (st_r.mode[CATS_MODE_DATA_RST]),
    .in_valid_i  (fifo_in_valid),
    .in_ready_o  (fifo_in_ready),
    .in_data_i   (drain_word),
    .out_valid_o (fifo_out_valid),
    .out_ready_i (ob_take),
    .out_data_o  (fifo_out_data)
  );

  assign bus_rsp_o.ack   = st_r.ack;
  assign bus_rsp_o.rdata = st_r.rdata;
  assign ob_wr_o         = st_r.ob;
  assign mode_o          = st_r.mode;
  assign read_test_address_o     = st_r.rd_addr;
  assign chassis_index_o         = st_r.chassis;
  assign baseline_current_code_o = st_r.baseline;
  assign slide_dac_o        = st_r.slide;
  assign sliding_scale_on_o = st_r.mode[CATS_MODE_SLIDE_ON];
  assign data_reset_o       = st_r.mode[CATS_MODE_DATA_RST];
  assign conv_trigger_o     = st_r.conv;
  assign event_count_o      = st_r.evcnt;
endmodule // cats_regs

/* File: cats_regs_properties.sv */
`timescale 1ns/1ps
module cats_regs_checker
  import cats_pkg::*;
#(
  parameter int EVCNT_W = 24
) (
  // Watched ports
  input wire logic               core_clk_i,
  input wire logic               rst_b_i,
  input wire cats_bus_req_s      bus_req_i,
  input wire cats_bus_rsp_s      bus_rsp_o,
  input wire cats_ob_wr_s        ob_wr_o,
  input wire logic [15:0]        mode_o,
  input wire logic [7:0]         chassis_index_o,
  input wire logic               data_reset_o,
  input wire logic               conv_trigger_o,
  input wire logic [EVCNT_W-1:0] event_count_o
);
  logic        wr;
  logic        rd;
  logic        sw_hit;
  logic [15:0] a;
  logic [15:0] d;
  logic [7:0]  d8;
  logic [15:0] upper_r;
  logic [10:0] waddr_r;
  assign wr     = bus_req_i.req & bus_req_i.we;
  assign rd     = bus_req_i.req & ~bus_req_i.we;
  assign a      = bus_req_i.addr;
  assign d      = bus_req_i.wdata;
  assign d8     = d[7:0];
  assign sw_hit = wr && a == CATS_OFF_SW_CONV;
  // Shadows let a commit be judged without seeing the body
  always_ff @(posedge core_clk_i) begin
    if (wr && a == CATS_OFF_PAT_UPPER) begin
      upper_r <= d;
    end
    if (wr && a == CATS_OFF_WR_ADDR) begin
      waddr_r <= d[10:0];
    end
  end
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!rst_b_i);
  sequence s_commit;
    wr && a == CATS_OFF_PAT_LOWER && mode_o[CATS_MODE_TEST_MEM];
  endsequence
  sequence s_placed;
    ob_wr_o.we && ob_wr_o.addr == waddr_r && ob_wr_o.data == {upper_r, $past(d)};
  endsequence
  chk_mem_commit: assert property (
    s_commit |=> s_placed) else $error("pattern commit wrong");
  chk_mode_read: assert property (
    rd && a == CATS_OFF_MODE_SET |=> bus_rsp_o.ack && bus_rsp_o.rdata == mode_o) else $error("mode read wrong");
  chk_wo_read: assert property (
    rd && (a == CATS_OFF_WR_ADDR || a == CATS_OFF_SW_CONV) |=> bus_rsp_o.ack && bus_rsp_o.rdata == 16'h0000
      && !conv_trigger_o) else $error("write-only read wrong");
  chk_sw_trigger: assert property (
    conv_trigger_o == $past(sw_hit)) else $error("trigger pulse wrong");
  chk_count_clear: assert property (
    wr && a == CATS_OFF_EVCNT_CLR |=> event_count_o == '0) else $error("count not cleared");
  chk_data_reset: assert property (
    mode_o[CATS_MODE_DATA_RST] |-> data_reset_o ##1 event_count_o == '0) else $error("data reset wrong");
  chk_clear_bits: assert property (
    wr && a == CATS_OFF_MODE_CLR |=> mode_o == ($past(mode_o) & ~$past(d))) else $error("mode clear wrong");
  chk_set_bits: assert property (
    wr && a == CATS_OFF_MODE_SET |=> mode_o == ($past(mode_o) | $past(d))) else $error("mode set wrong");
  chk_chassis_store: assert property (
    wr && a == CATS_OFF_CHASSIS |=> chassis_index_o == $past(d8)) else $error("chassis store wrong");
  chk_acq_word: assert property (
    ob_wr_o.we && mode_o[CATS_MODE_ACQUISITION_TEST_SELECT] && !mode_o[CATS_MODE_TEST_MEM]
      |-> ob_wr_o.data[31:13] == {8'h00, $past(chassis_index_o), 3'h0}) else $error("test event word wrong");
endmodule // cats_regs_checker

bind cats_regs cats_regs_checker #(.EVCNT_W(EVCNT_W)) u_chk (
  .core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .bus_req_i(bus_req_i), .bus_rsp_o(bus_rsp_o),
  .ob_wr_o(ob_wr_o), .mode_o(mode_o), .chassis_index_o(chassis_index_o), .data_reset_o(data_reset_o),
  .conv_trigger_o(conv_trigger_o), .event_count_o(event_count_o));

/* File: charge_adc_test_and_setup_regs_bench.sv */
`timescale 1ns/1ps
module charge_adc_test_and_setup_regs_bench;
  import cats_pkg::*;
  logic          core_clk_i;
  logic          rst_b_i;
  cats_bus_req_s req;
  cats_bus_rsp_s rsp;
  cats_ob_wr_s   ob;
  logic [11:0]   sa;
  logic [11:0]   sb;
  logic          inc;
  logic          ob_rdy;
  logic [15:0]   mode;
  logic [10:0]   raddr;
  logic [7:0]    chas;
  logic [7:0]    base;
  logic [7:0]    base_old;
  logic [7:0]    sdac;
  logic          son;
  logic          drst;
  logic          conv;
  logic [23:0]   evc;
  logic [15:0]   q;
  int            n_errors;
  int            samples_checked;
  int            cyc;

  cats_regs #(.NEW_FRONT_END(1'b1)) dut (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .bus_req_i(req),
    .bus_rsp_o(rsp), .block_a_raw_sample_i(sa), .block_b_raw_sample_i(sb), .event_inc_i(inc), .ob_wr_o(ob),
    .ob_ready_i(ob_rdy), .mode_o(mode), .read_test_address_o(raddr), .chassis_index_o(chas),
    .baseline_current_code_o(base), .slide_dac_o(sdac), .sliding_scale_on_o(son), .data_reset_o(drst),
    .conv_trigger_o(conv), .event_count_o(evc));
  cats_regs #(.NEW_FRONT_END(1'b0)) dut_old (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i), .bus_req_i(req),
    .bus_rsp_o(), .block_a_raw_sample_i(sa), .block_b_raw_sample_i(sb), .event_inc_i(inc), .ob_wr_o(),
    .ob_ready_i(ob_rdy), .mode_o(), .read_test_address_o(), .chassis_index_o(),
    .baseline_current_code_o(base_old), .slide_dac_o(), .sliding_scale_on_o(), .data_reset_o(),
    .conv_trigger_o(), .event_count_o());
  cats_host_model host (.core_clk_i(core_clk_i), .bus_req_o(req), .bus_rsp_i(rsp));

  always #25 core_clk_i = ~core_clk_i;

  task automatic summarize;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Generous ceiling; the whole sequence needs well under a thousand cycles
  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      summarize();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    host.xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    host.xfer(1'b0, a, 16'h0000, q);
    chk(q, exp);
  endtask
  task automatic pulse3;
    @(posedge core_clk_i);
    inc <= 1'b1;
    repeat (3) @(posedge core_clk_i);
    inc <= 1'b0;
    @(posedge core_clk_i);
  endtask

  task automatic t_mode;
    rd(CATS_OFF_MODE_SET, CATS_MODE_RST);
    chk(base, CATS_BASE_RST_NEW);
    chk(base_old, CATS_BASE_RST_OLD);
    wr(CATS_OFF_MODE_SET, 16'h0004);
    chk(drst, 1'b1);
    pulse3();
    chk(evc, 24'h000000);
    wr(CATS_OFF_MODE_CLR, 16'h0004);
    rd(CATS_OFF_MODE_SET, 16'h0080);
    wr(CATS_OFF_MODE_SET, 16'h0003);
    wr(CATS_OFF_MODE_CLR, 16'h0082);
    rd(CATS_OFF_MODE_SET, 16'h0001);
    chk(son, 1'b0);
  endtask

  task automatic t_regs;
    logic [15:0] offs [3] = '{CATS_OFF_SLIDE, CATS_OFF_BASELINE, CATS_OFF_CHASSIS};
    logic [7:0]  vals [3] = '{8'h7e, 8'h3c, 8'h5a};
    for (int i = 0; i < 3; i++) begin
      wr(offs[i], {8'ha5, vals[i]});
      rd(offs[i], {8'h00, vals[i]});
    end
    chk({8'h00, sdac, base, chas}, 32'h007e3c5a);
    rd(CATS_OFF_WR_ADDR, 16'h0000);
    wr(16'h1042, 16'hffff);
    rd(16'h1042, 16'h0000);
  endtask

  task automatic t_mem;
    wr(CATS_OFF_RD_ADDR, 16'hf805);
    chk(raddr, 11'h005);
    wr(CATS_OFF_WR_ADDR, 16'hf7ff);
    wr(CATS_OFF_PAT_UPPER, 16'hcafe);
    wr(CATS_OFF_PAT_LOWER, 16'h1234);
    chk({ob.we, ob.addr}, {1'b1, 11'h7ff});
    chk(ob.data, 32'hcafe1234);
    wr(CATS_OFF_MODE_CLR, 16'h0001);
    wr(CATS_OFF_PAT_LOWER, 16'h5555);
    chk(ob.we, 1'b0);
    wr(CATS_OFF_MODE_SET, 16'h0080);
    chk(son, 1'b1);
  endtask

  task automatic t_conv;
    wr(CATS_OFF_SW_CONV, 16'h0000);
    chk(conv, 1'b1);
    rd(CATS_OFF_SW_CONV, 16'h0000);
    chk(conv, 1'b0);
    pulse3();
    chk(evc, 24'h000003);
    wr(CATS_OFF_EVCNT_CLR, 16'hffff);
    chk(evc, 24'h000000);
    @(posedge core_clk_i);
    sa <= 12'habc;
    sb <= 12'h123;
    repeat (5) @(posedge core_clk_i);
    rd(CATS_OFF_BLOCK_A, 16'h0abc);
    rd(CATS_OFF_BLOCK_B, 16'h0123);
  endtask

  task automatic t_acq;
    int n;
    n = 0;
    for (int i = 0; i < 32; i++) wr(CATS_OFF_TEST_EVT, {3'h0, i[0], 12'(i * 37)});
    wr(CATS_OFF_MODE_SET, 16'h0040);
    // Ready toggles so the drain keeps stalling
    repeat (400) begin
      @(posedge core_clk_i);
      ob_rdy <= ~ob_rdy;
      if (ob.we === 1'b1) begin
        chk(ob.addr, n);
        chk(ob.data, {8'h00, 8'h5a, 3'h0, n[0], 12'(n * 37)});
        n++;
      end
    end
    chk(n, 32);
  endtask

  initial begin
    core_clk_i = 1'b0;
    rst_b_i = 1'b0;
    inc = 1'b0;
    ob_rdy = 1'b0;
    sa = 12'h000;
    sb = 12'h000;
    n_errors = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (2) @(posedge core_clk_i);
    rst_b_i <= 1'b1;
    t_mode();
    t_regs();
    t_mem();
    t_conv();
    t_acq();
    summarize();
  end
endmodule // charge_adc_test_and_setup_regs_bench
